// ==== design/mcd_pkg.sv ====
// Constants for the maintenance counter and display block
// Function
// R1 - Power-on hour counter wraps past 65535
// R2 - Hour display 1-hour units, then 10-hour units
// R3 - Board capacitor hours saturate at 65535
// R4 - Fan hours count while fan runs, or every hour when fan on/off control is off
// R5 - Startup counter per run command, wraps
// R6 - Startup display 0.001 steps, then 0.01
// R7 - RS485 error count wraps past 9999
// R8 - Latest RS485 error code shown decimal
// R9 - Hourly peak heat-sink temperature
// R10 - Hourly peak effective output current
// R11 - Capacitance percent versus shipment value
// R12 - Drive firmware version as four digits
// R13 - Keypad version only with remote keypad
// R14 - Item selector from 5_00, return steps back
// R15 - Menu reachable only when menu level 2
// R16 - Running mode at power-up, key to programming
// R17 - Comm view adds forward, reverse, reset bits
// R18 - Comm view shows uninverted signals
// R19 - Hex view packs 16 bits, four digits
// R20 - Prescaler derives one-hour tick
// R21 - Peaks latch at tick then restart
package mcd_pkg;
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned HOUR_S = 3600;
  localparam longint unsigned HOUR_CYC = longint'(CLK_HZ) * longint'(HOUR_S);
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [15:0] ERR_MAX = 16'h270F;
  localparam logic [15:0] TEN_K = 16'h2710;
  localparam logic [15:0] SHIP_PCT = 16'h0064;
  localparam logic [3:0] ITEM_LAST = 4'hA;
  localparam logic [1:0] FULL_MENU = 2'h2;
  localparam logic [3:0] SEL_MAINT = 4'h5;
  localparam logic [3:0] BIT_COMM_FWD = 4'hD;
  localparam logic [3:0] BIT_COMM_REV = 4'hE;
  localparam logic [3:0] BIT_COMM_RST = 4'hF;
  localparam logic [7:0] ITEM_HOURS = 8'h00;
  localparam logic [7:0] ITEM_DCLINK = 8'h01;
  localparam logic [7:0] ITEM_TEMP = 8'h03;
  localparam logic [7:0] ITEM_CURR = 8'h04;
  localparam logic [7:0] ITEM_CAP = 8'h05;
  localparam logic [7:0] ITEM_PCBCAP = 8'h06;
  localparam logic [7:0] ITEM_FAN = 8'h07;
  localparam logic [7:0] ITEM_STARTS = 8'h08;
  localparam logic [7:0] ITEM_ERRCNT = 8'h11;
  localparam logic [7:0] ITEM_ERRCODE = 8'h12;
  localparam logic [7:0] ITEM_DRVVER = 8'h14;
  localparam logic [7:0] ITEM_PADVER = 8'h16;
  typedef enum logic [1:0] {
    MCD_RUNNING = 2'b00,
    MCD_MENU = 2'b01,
    MCD_LIST = 2'b11,
    MCD_DATA = 2'b10
  } mcd_state_t;
endpackage

// ==== design/mcd_top.sv ====
// Maintenance counters, menu navigation and LED monitor formatting
`timescale 1ns/1ps
module mcd_top #(
  parameter longint unsigned HOUR_CYCLES = mcd_pkg::HOUR_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_run_cmd,
  input wire logic i_fan_running,
  input wire logic i_fan_onoff_control,
  input wire logic i_comm_err,
  input wire logic [15:0] i_comm_err_code,
  input wire logic [15:0] i_heatsink_temp,
  input wire logic [15:0] i_out_current,
  input wire logic [15:0] i_cap_now,
  input wire logic [15:0] i_cap_ship,
  input wire logic [15:0] i_drv_version,
  input wire logic [15:0] i_pad_version,
  input wire logic i_remote_pad,
  input wire logic [1:0] i_menu_level_select,
  input wire logic i_key_prg,
  input wire logic i_key_up,
  input wire logic i_key_down,
  input wire logic i_key_func,
  input wire logic [3:0] i_menu_sel,
  input wire logic i_comm_mode,
  input wire logic [4:0] i_term_in,
  input wire logic i_y1_out,
  input wire logic i_relay_out,
  input wire logic i_comm_forward_cmd,
  input wire logic i_comm_reverse_cmd,
  input wire logic i_comm_reset_cmd,
  output logic [1:0] o_mode,
  output logic o_maintenance_menu_entry,
  output logic [7:0] o_item_code,
  output logic o_show_data,
  output logic [15:0] o_disp_value,
  output logic [1:0] o_disp_point,
  output logic [15:0] o_io_in_hex,
  output logic [15:0] o_io_out_hex,
  output logic [7:0] o_io_seg,
  output logic o_hour_tick,
  output logic [15:0] o_hours,
  output logic [15:0] o_starts,
  output logic [15:0] o_err_count
);
  import mcd_pkg::*;

  // ==========================================================
  // Input synchronisers for pins (three stages)
  // ==========================================================
  logic [5:0] pin_s1_reg;
  logic [5:0] pin_s2_reg;
  logic [5:0] pin_s3_reg;
  logic [5:0] pin_reg;
  logic [5:0] pin_raw;
  assign pin_raw = {i_relay_out, i_term_in};

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pin_s1_reg <= 6'h00;
      pin_s2_reg <= 6'h00;
      pin_s3_reg <= 6'h00;
      pin_reg <= 6'h00;
    end else if (i_ce) begin
      pin_s1_reg <= pin_raw;
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
      for (int i = 0; i < 6; i++) begin
        if (pin_s2_reg[i] == pin_s3_reg[i]) begin
          pin_reg[i] <= pin_s3_reg[i];
        end
      end
    end
  end

  // ==========================================================
  // Hour prescaler
  // ==========================================================
  logic [37:0] pre_reg;
  logic tick;
  assign tick = (pre_reg == 38'(HOUR_CYCLES - 1));

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pre_reg <= 38'h0;
      o_hour_tick <= 1'b0;
    end else if (i_ce) begin
      pre_reg <= tick ? 38'h0 : pre_reg + 38'h1; // R20
      o_hour_tick <= tick;
    end
  end

  // ==========================================================
  // Hour counters
  // ==========================================================
  logic [15:0] pcb_hours_reg;
  logic [15:0] fan_hours_reg;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_hours <= 16'h0000;
      pcb_hours_reg <= 16'h0000;
      fan_hours_reg <= 16'h0000;
    end else if (i_ce && tick) begin
      o_hours <= o_hours + 16'h0001; // R1
      if (pcb_hours_reg != CNT_MAX) begin
        pcb_hours_reg <= pcb_hours_reg + 16'h0001; // R3
      end
      if (fan_hours_reg != CNT_MAX && (i_fan_running || !i_fan_onoff_control)) begin
        fan_hours_reg <= fan_hours_reg + 16'h0001; // R4
      end
    end
  end

  // ==========================================================
  // Startup and RS485 error counters
  // ==========================================================
  logic run_d_reg;
  logic [15:0] err_code_reg;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      run_d_reg <= 1'b0;
      o_starts <= 16'h0000;
    end else if (i_ce) begin
      run_d_reg <= i_run_cmd;
      if (i_run_cmd && !run_d_reg) begin
        o_starts <= o_starts + 16'h0001; // R5
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_err_count <= 16'h0000;
      err_code_reg <= 16'h0000;
    end else if (i_ce && i_comm_err) begin
      o_err_count <= (o_err_count == ERR_MAX) ? 16'h0000 : o_err_count + 16'h0001; // R7
      err_code_reg <= i_comm_err_code; // R8
    end
  end

  // ==========================================================
  // Hourly peak trackers
  // ==========================================================
  logic [15:0] temp_run_reg;
  logic [15:0] curr_run_reg;
  logic [15:0] temp_peak_reg;
  logic [15:0] curr_peak_reg;

  function automatic logic [15:0] max16(input logic [15:0] a, input logic [15:0] b);
    max16 = (a > b) ? a : b;
  endfunction

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      temp_run_reg <= 16'h0000;
      curr_run_reg <= 16'h0000;
      temp_peak_reg <= 16'h0000;
      curr_peak_reg <= 16'h0000;
    end else if (i_ce) begin
      if (tick) begin
        temp_peak_reg <= max16(temp_run_reg, i_heatsink_temp); // R9 R21
        curr_peak_reg <= max16(curr_run_reg, i_out_current); // R10 R21
        temp_run_reg <= 16'h0000;
        curr_run_reg <= 16'h0000;
      end else begin
        temp_run_reg <= max16(temp_run_reg, i_heatsink_temp); // R9
        curr_run_reg <= max16(curr_run_reg, i_out_current); // R10
      end
    end
  end

  // ==========================================================
  // Capacitance percentage
  // ==========================================================
  logic [15:0] cap_pct;
  logic [22:0] cap_prod;
  assign cap_prod = 23'(i_cap_now) * 23'(SHIP_PCT);
  assign cap_pct = (i_cap_ship == 16'h0000) ? 16'h0000
                   : 16'(cap_prod / 23'(i_cap_ship)); // R11

  // ==========================================================
  // Menu navigation
  // ==========================================================
  mcd_state_t state_reg;
  logic [3:0] idx_reg;
  logic [3:0] idx_max;
  assign idx_max = i_remote_pad ? ITEM_LAST + 4'h1 : ITEM_LAST; // R13

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_reg <= MCD_RUNNING; // R16
      idx_reg <= 4'h0;
    end else if (i_ce) begin
      case (state_reg)
        MCD_RUNNING: begin
          if (i_key_prg) begin
            state_reg <= MCD_MENU; // R16
          end
        end
        MCD_MENU: begin
          if (i_key_prg) begin
            state_reg <= MCD_RUNNING;
          end else if (i_key_func && i_menu_sel == SEL_MAINT
                       && i_menu_level_select == FULL_MENU) begin
            state_reg <= MCD_LIST; // R15
            idx_reg <= 4'h0; // R14
          end
        end
        MCD_LIST: begin
          if (i_key_prg) begin
            state_reg <= MCD_MENU; // R14
          end else if (i_key_func) begin
            state_reg <= MCD_DATA; // R14
          end else if (i_key_up) begin
            idx_reg <= (idx_reg >= idx_max) ? 4'h0 : idx_reg + 4'h1;
          end else if (i_key_down) begin
            idx_reg <= (idx_reg == 4'h0) ? idx_max : idx_reg - 4'h1;
          end
        end
        MCD_DATA: begin
          if (i_key_prg) begin
            state_reg <= MCD_LIST; // R14
          end
        end
        default: begin
          state_reg <= MCD_RUNNING;
        end
      endcase
    end
  end

  // ==========================================================
  // Item decode and display formatting
  // ==========================================================
  function automatic logic [7:0] item_of(input logic [3:0] idx);
    case (idx)
      4'h0: item_of = ITEM_HOURS;
      4'h1: item_of = ITEM_DCLINK;
      4'h2: item_of = ITEM_TEMP;
      4'h3: item_of = ITEM_CURR;
      4'h4: item_of = ITEM_CAP;
      4'h5: item_of = ITEM_PCBCAP;
      4'h6: item_of = ITEM_FAN;
      4'h7: item_of = ITEM_STARTS;
      4'h8: item_of = ITEM_ERRCNT;
      4'h9: item_of = ITEM_ERRCODE;
      4'hA: item_of = ITEM_DRVVER;
      default: item_of = ITEM_PADVER;
    endcase
  endfunction

  // Scaled form: below 10000 in units of one, from 10000 up in units of ten
  function automatic logic [15:0] scale(input logic [15:0] v);
    scale = (v < TEN_K) ? v : 16'(v / 16'h000A);
  endfunction

  function automatic logic [1:0] point(input logic [15:0] v);
    point = (v < TEN_K) ? 2'h3 : 2'h2;
  endfunction

  logic [7:0] item_cur;
  logic [15:0] val_next;
  logic [1:0] pt_next;
  // Index past the end after keypad removal shows the first item
  assign item_cur = (idx_reg > idx_max) ? item_of(4'h0) : item_of(idx_reg); // R13

  always_comb begin
    val_next = 16'h0000;
    pt_next = 2'h0;
    case (item_cur)
      ITEM_HOURS: begin
        val_next = scale(o_hours); // R2
        pt_next = point(o_hours);
      end
      ITEM_PCBCAP: begin
        val_next = scale(pcb_hours_reg); // R3
        pt_next = point(pcb_hours_reg);
      end
      ITEM_FAN: begin
        val_next = scale(fan_hours_reg); // R4
        pt_next = point(fan_hours_reg);
      end
      ITEM_STARTS: begin
        val_next = scale(o_starts); // R6
        pt_next = point(o_starts);
      end
      ITEM_TEMP: val_next = temp_peak_reg;
      ITEM_CURR: val_next = curr_peak_reg;
      ITEM_CAP: val_next = cap_pct;
      ITEM_ERRCNT: val_next = o_err_count;
      ITEM_ERRCODE: val_next = err_code_reg; // R8
      ITEM_DRVVER: val_next = i_drv_version; // R12
      ITEM_PADVER: val_next = i_remote_pad ? i_pad_version : 16'h0000; // R13
      default: val_next = 16'h0000;
    endcase
  end

  // ==========================================================
  // I/O status views
  // ==========================================================
  logic [15:0] in_hex_next;
  always_comb begin
    in_hex_next = 16'h0000; // R19
    in_hex_next[4:0] = pin_reg[4:0];
    if (i_comm_mode) begin
      in_hex_next[BIT_COMM_FWD] = i_comm_forward_cmd; // R17 R18
      in_hex_next[BIT_COMM_REV] = i_comm_reverse_cmd; // R17 R18
      in_hex_next[BIT_COMM_RST] = i_comm_reset_cmd; // R17 R18
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_io_in_hex <= 16'h0000;
      o_io_out_hex <= 16'h0000;
      o_io_seg <= 8'h00;
    end else if (i_ce) begin
      o_io_in_hex <= in_hex_next; // R19
      o_io_out_hex <= {7'h00, pin_reg[5], 7'h00, i_y1_out}; // R19
      o_io_seg <= {in_hex_next[BIT_COMM_RST], in_hex_next[BIT_COMM_REV],
                   in_hex_next[BIT_COMM_FWD], pin_reg[4:0]}; // R17
    end
  end

  // ==========================================================
  // Registered display outputs
  // ==========================================================
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_mode <= 2'b00;
      o_maintenance_menu_entry <= 1'b0;
      o_item_code <= 8'h00;
      o_show_data <= 1'b0;
      o_disp_value <= 16'h0000;
      o_disp_point <= 2'h0;
    end else if (i_ce) begin
      o_mode <= state_reg;
      o_maintenance_menu_entry <= (state_reg == MCD_MENU) && (i_menu_sel == SEL_MAINT)
                                  && (i_menu_level_select == FULL_MENU); // R15
      o_item_code <= item_cur; // R14
      o_show_data <= (state_reg == MCD_DATA);
      o_disp_value <= val_next;
      o_disp_point <= pt_next;
    end
  end
endmodule

// ==== test/mcd_pad_model.sv ====
// Keypad and RS485 host model that sends key pulses and error reports
`timescale 1ns/1ps
module mcd_pad_model (
  input wire logic i_clk,
  output logic o_prg,
  output logic o_up,
  output logic o_down,
  output logic o_func,
  output logic o_err,
  output logic [15:0] o_code
);
  initial begin
    {o_prg, o_up, o_down, o_func, o_err} = 5'h00;
    o_code = 16'h0;
  end
  // One-cycle key pulse (0 func, 1 up, 2 prg, 3 down), then a settle gap
  task automatic press(input int k);
    @(negedge i_clk);
    {o_down, o_prg, o_up, o_func} = 4'(4'h1 << k);
    @(negedge i_clk);
    {o_down, o_prg, o_up, o_func} = 4'h0;
    repeat (4) @(negedge i_clk);
  endtask
  // Error pulse with its code; the released code lines carry a changed pattern
  task automatic report(input logic [15:0] c);
    @(negedge i_clk);
    o_err = 1'b1;
    o_code = c;
    @(negedge i_clk);
    o_err = 1'b0;
    o_code = ~c;
  endtask
endmodule

// ==== test/mcd_sva.sv ====
// Concurrent checks on the maintenance counter block ports
`timescale 1ns/1ps
module mcd_sva #(
  parameter longint unsigned HOUR_CYCLES = 20
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_key_prg,
  input wire logic i_key_func,
  input wire logic [1:0] i_menu_level_select,
  input wire logic i_comm_mode,
  input wire logic i_comm_forward_cmd,
  input wire logic [1:0] o_mode,
  input wire logic o_hour_tick,
  input wire logic [15:0] o_hours,
  input wire logic [15:0] o_starts,
  input wire logic [15:0] o_err_count,
  input wire logic [15:0] o_io_in_hex,
  input wire logic [7:0] o_io_seg
);
  import mcd_pkg::*;
  longint unsigned gap_reg;
  logic seen_reg;
  // ======
  // Enabled cycles since the last hour tick
  always_ff @(posedge i_clk) begin
    if (i_rst || (o_hour_tick && i_ce)) begin
      gap_reg <= '0;
    end else if (i_ce) begin
      gap_reg <= gap_reg + 1;
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      seen_reg <= 1'b0;
    end else if (o_hour_tick && i_ce) begin
      seen_reg <= 1'b1;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  a_tick_period: assert property (o_hour_tick && i_ce && seen_reg |-> gap_reg == HOUR_CYCLES - 1)
    else $error("hour tick spacing wrong");
  a_hours_step: assert property ($changed(o_hours) |-> o_hours == $past(o_hours) + 16'h1)
    else $error("hour count step wrong");
  a_starts_step: assert property ($changed(o_starts) |-> o_starts == $past(o_starts) + 16'h1)
    else $error("startup count step wrong");
  a_err_wrap: assert property ($changed(o_err_count) |-> o_err_count ==
    (($past(o_err_count) == ERR_MAX) ? 16'h0 : $past(o_err_count) + 16'h1))
    else $error("error count step wrong");
  a_prg_enter: assert property (o_mode == MCD_RUNNING && i_key_prg |-> ##[2:3] o_mode == MCD_MENU)
    else $error("program key did not open menu");
  a_level_gate: assert property (o_mode == MCD_MENU && i_key_func &&
    i_menu_level_select != FULL_MENU |-> ##3 o_mode == MCD_MENU)
    else $error("menu left without full level");
  a_comm_off: assert property (!i_comm_mode [*2] |-> o_io_in_hex[15:13] == 3'h0)
    else $error("comm bits shown outside comm control");
  a_comm_fwd: assert property ((i_comm_mode && i_comm_forward_cmd) [*2] |->
    o_io_in_hex[13] && o_io_seg[5])
    else $error("forward command not shown");
  cover property (o_hour_tick && seen_reg);
  cover property (o_mode == MCD_DATA);
  cover property ($past(o_err_count) == ERR_MAX && o_err_count == 16'h0);
endmodule
bind mcd_top mcd_sva #(.HOUR_CYCLES(HOUR_CYCLES)) mcd_sva_inst (
  .i_clk(i_clk),
  .i_rst(i_rst),
  .i_ce(i_ce),
  .i_key_prg(i_key_prg),
  .i_key_func(i_key_func),
  .i_menu_level_select(i_menu_level_select),
  .i_comm_mode(i_comm_mode),
  .i_comm_forward_cmd(i_comm_forward_cmd),
  .o_mode(o_mode),
  .o_hour_tick(o_hour_tick),
  .o_hours(o_hours),
  .o_starts(o_starts),
  .o_err_count(o_err_count),
  .o_io_in_hex(o_io_in_hex),
  .o_io_seg(o_io_seg)
);

// ==== test/testbench.sv ====
// Self-checking bench for the maintenance counter and display block
`timescale 1ns/1ps
module testbench;
  import mcd_pkg::*;
  localparam longint unsigned HC = 20;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic run = 1'b0;
  logic ce = 1'b1;
  logic fanrun = 1'b1;
  logic fanctl = 1'b1;
  logic fan_q = 1'b0;
  logic [3:0] msel = 4'h5;
  logic rpad = 1'b0;
  logic cmode = 1'b0;
  logic y1 = 1'b0;
  logic relay = 1'b0;
  logic [2:0] cmd = 3'h0;
  logic [4:0] term = 5'h0;
  logic [1:0] lvl = 2'h1;
  logic [15:0] temp = 16'h0, curr = 16'h0, capn = 16'h0, caps = 16'h1;
  logic [15:0] drv = 16'h0, padv = 16'h0;
  logic prg, up, down, func, cerr, tick, entry, show;
  logic [15:0] code, dv, ioin, ioout, hours, starts, errc, v, mx;
  logic [7:0] item, ioseg;
  logic [1:0] mode, dp;
  logic [7:0] codes [12] = '{8'h00, 8'h01, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08,
    8'h11, 8'h12, 8'h14, 8'h16};
  int tgt [2] = '{9999, 10005};
  int seed = 32'hB2BA;
  int err_total = 0;
  int samples_checked = 0;
  int nticks = 0;
  int nstart = 0;
  int nfan = 0;
  int cyc = 0;
  int pos = 0;
  mcd_top #(.HOUR_CYCLES(HC)) mcd_top_inst (
    .i_clk(i_clk), .i_rst(i_rst), .i_ce(ce), .i_run_cmd(run), .i_fan_running(fanrun),
    .i_fan_onoff_control(fanctl), .i_comm_err(cerr), .i_comm_err_code(code),
    .i_heatsink_temp(temp), .i_out_current(curr), .i_cap_now(capn), .i_cap_ship(caps),
    .i_drv_version(drv), .i_pad_version(padv), .i_remote_pad(rpad),
    .i_menu_level_select(lvl), .i_key_prg(prg), .i_key_up(up), .i_key_down(down),
    .i_key_func(func), .i_menu_sel(msel), .i_comm_mode(cmode), .i_term_in(term),
    .i_y1_out(y1), .i_relay_out(relay), .i_comm_forward_cmd(cmd[0]),
    .i_comm_reverse_cmd(cmd[1]), .i_comm_reset_cmd(cmd[2]), .o_mode(mode),
    .o_maintenance_menu_entry(entry), .o_item_code(item), .o_show_data(show),
    .o_disp_value(dv), .o_disp_point(dp), .o_io_in_hex(ioin), .o_io_out_hex(ioout),
    .o_io_seg(ioseg), .o_hour_tick(tick), .o_hours(hours), .o_starts(starts),
    .o_err_count(errc)
  );
  mcd_pad_model mcd_pad_model_inst (.i_clk(i_clk), .o_prg(prg), .o_up(up), .o_down(down),
    .o_func(func), .o_err(cerr), .o_code(code));
  always #12.5 i_clk = ~i_clk;
  // ======
  // Helpers
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("Checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  function automatic logic [17:0] scaled(input logic [15:0] x);
    return (x < TEN_K) ? {x, 2'h3} : {x / 16'hA, 2'h2};
  endfunction
  task automatic key(input int k);
    mcd_pad_model_inst.press(k);
  endtask
  // Opens item idx from the menu, then settles just after an hour tick
  task automatic view(input int idx);
    key(0);
    repeat (idx) key(1);
    key(0);
    @(posedge i_clk iff tick === 1'b1);
    repeat (3) @(negedge i_clk);
    check(show, 1'b1);
  endtask
  task automatic back;
    key(2);
    key(2);
  endtask
  always @(posedge i_clk) begin
    cyc++;
    if (tick === 1'b1 && ce) nticks++;
    // Fan hours follow the fan state at the enabled edge before the tick pulse
    if (tick === 1'b1 && ce && fan_q) nfan++;
    if (ce) fan_q = fanrun || !fanctl;
    if (cyc == 80000) begin
      err_total++;
      wrap_up();
    end
  end
  // ======
  // Scenarios
  initial begin
    repeat (16) @(negedge i_clk);
    i_rst = 1'b0;
    check(mode, MCD_RUNNING);
    key(2);
    check(mode, MCD_MENU);
    key(0);
    check({entry, mode}, {1'b0, MCD_MENU});
    lvl = FULL_MENU;
    msel = 4'h4;
    key(0);
    check({entry, mode}, {1'b0, MCD_MENU});
    msel = SEL_MAINT;
    repeat (3) @(negedge i_clk);
    check(entry, 1'b1);
    key(0);
    check({mode, item}, {MCD_LIST, 8'h00});
    for (int r = 0; r < 2; r++) begin
      rpad = r[0];
      repeat (12) begin
        key(1);
        pos = (pos + 1) % (11 + r);
        check(item, codes[pos]);
      end
    end
    repeat (2) begin
      key(3);
      pos = (pos + 11) % 12;
      check(item, codes[pos]);
    end
    key(2);
    $display("menu done");
    repeat (8) begin
      @(negedge i_clk);
      cmode = 1'($random(seed));
      cmd = 3'($random(seed));
      term = 5'($random(seed));
      y1 = 1'($random(seed));
      relay = 1'($random(seed));
      repeat (10) @(negedge i_clk);
      check(ioin, {cmode ? cmd : 3'h0, 8'h0, term});
      check(ioout, {7'h0, relay, 7'h0, y1});
      check(ioseg, {cmode ? cmd : 3'h0, term});
    end
    $display("io done");
    for (int j = 2; j < 4; j++) begin
      view(j);
      mx = 16'h0;
      repeat (4) begin
        v = 16'($random(seed)) | 16'h0100;
        temp = v;
        curr = v;
        if (v > mx) mx = v;
        repeat (3) @(negedge i_clk);
      end
      temp = 16'h1;
      curr = 16'h1;
      @(posedge i_clk iff tick === 1'b1);
      repeat (3) @(negedge i_clk);
      check(dv, mx);
      @(posedge i_clk iff tick === 1'b1);
      repeat (3) @(negedge i_clk);
      check(dv, 16'h1);
      back;
    end
    $display("peak done");
    fanrun = 1'b0;
    ce = 1'b0;
    mx = hours;
    repeat (60) @(negedge i_clk);
    check(hours, mx);
    ce = 1'b1;
    view(0);
    check({dv, dp}, scaled(16'(nticks)));
    check(hours, nticks);
    back;
    view(5);
    check({dv, dp}, scaled(16'(nticks)));
    back;
    view(6);
    check({dv, dp}, scaled(16'(nfan)));
    back;
    fanctl = 1'b0;
    foreach (tgt[t]) begin
      while (nstart < tgt[t]) begin
        @(negedge i_clk);
        run = 1'b1;
        @(negedge i_clk);
        run = 1'b0;
        nstart++;
      end
      view(7);
      check({dv, dp}, scaled(16'(nstart)));
      check(starts, nstart);
      back;
    end
    $display("count done");
    view(6);
    check({dv, dp}, scaled(16'(nfan)));
    back;
    repeat (10001) begin
      v = 16'($random(seed));
      mcd_pad_model_inst.report(v);
    end
    view(8);
    check({errc, dv}, {16'h1, 16'h1});
    back;
    view(9);
    check(dv, v);
    back;
    drv = 16'($random(seed));
    padv = 16'($random(seed));
    caps = 16'($random(seed)) | 16'h8000;
    capn = caps - 16'($random(seed) & 32'h0FFF);
    view(4);
    check(dv, 32'(capn) * 100 / caps);
    back;
    view(10);
    check(dv, drv);
    back;
    view(11);
    check(dv, padv);
    $display("data done");
    wrap_up();
  end
endmodule
